// File: hdl/axis_drive_defines.vh
// register offsets, field positions, command codes and reset values of the axis drive
`ifndef AXIS_DRIVE_DEFINES_VH
`define AXIS_DRIVE_DEFINES_VH

// register byte offsets
`define REG_CMD          8'h00
`define REG_POS_PARAM    8'h04
`define REG_CONFIG       8'h08
`define REG_PULSE_DIV    8'h0C
`define REG_SOFT_PLUS    8'h10
`define REG_SOFT_MINUS   8'h14
`define REG_LOGICAL_POS  8'h18
`define REG_DRIVE_STAT   8'h1C
`define REG_ERROR_STAT   8'h20
`define REG_INT_STAT     8'h24
`define REG_INT_MASK     8'h28

// command codes, written to the low byte of the command register
`define CMD_REL_DRIVE    8'h01
`define CMD_CREL_DRIVE   8'h02
`define CMD_ABS_DRIVE    8'h03
`define CMD_DECEL_STOP   8'h04
`define CMD_INSTANT_STOP 8'h05
`define CMD_ERR_CLEAR    8'h79
`define CMD_SOFT_RESET   8'hFF

// config register fields
`define CFG_HW_PLUS_EN   0
`define CFG_HW_MINUS_EN  1
`define CFG_SOFT_EN      2
`define CFG_SOFT_INSTANT 3
`define CFG_WIDTH        4
`define CFG_RESET        4'h3

// error status register fields
`define ERR_SOFT_PLUS    0
`define ERR_SOFT_MINUS   1
`define ERR_HW_PLUS      2
`define ERR_HW_MINUS     3
`define ERR_ALARM        4
`define ERR_EMG          5
`define ERR_WIDTH        6

// interrupt status fields
`define INT_FINISH       0
`define INT_ERROR        1
`define INT_WIDTH        2

// direction level on the direction output
`define DIR_PLUS         1'b1
`define DIR_MINUS        1'b0

// pulse half period in clocks, and decelerating stop length in pulses
`define PULSE_DIV_RESET  16'h0064
`define DECEL_PULSES     3'h4
`define SOFT_PLUS_RESET  32'h7FFFFFFF
`define SOFT_MINUS_RESET 32'h80000000

`endif

// File: hdl/axis_drive_error_limit_logic.v
// one motion axis: position drives, sticky error bits, hardware and software limits
//
// Summary of operation
// [RULE1] relative drive: positive count goes plus, negative count goes minus
// [RULE2] counter relative drive: positive count is output in the minus direction
// [RULE3] absolute drive runs until logical position equals the programmed destination
// [RULE4] error bit sets if its source is active during a drive or at start
// [RULE5] error bits stay set after their source goes inactive
// [RULE6] sources active while idle set no error bit
// [RULE7] error clear command or next drive start clears all error bits
// [RULE8] host clears errors only after confirming an interpolation drive has stopped
// [RULE9] software enables or disables each hardware limit input
// [RULE10] soft limit values live in dedicated registers, not compare registers
// [RULE11] soft limit stops with decelerating or instant stop as software selects
// [RULE12] soft limit compares position to plus value going plus, minus going minus
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "axis_drive_defines.vh"

module axis_drive_error_limit_logic (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // register port
  input  wire [7:0]  addr_in,
  input  wire [31:0] wr_data_in,
  input  wire        wr_en_in,
  input  wire        rd_en_in,
  output reg  [31:0] rd_data_out,
  // driver side inputs
  input  wire        plus_limit_input_n_in,
  input  wire        minus_limit_input_n_in,
  input  wire        servo_alarm_in,
  input  wire        emg_stop_n_in,
  // driver side outputs, and the host interrupt
  output reg         pulse_out,
  output reg         dir_out,
  output reg         irq_out
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_RUN   = 3'b010;
  localparam [2:0] ST_DECEL = 3'b100;

  function [31:0] magnitude;
    input [31:0] v;
    begin
      magnitude = v[31] ? (~v + 32'h1) : v;
    end
  endfunction

  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [31:0]             pos_param_r;
  reg  [`CFG_WIDTH-1:0]   config_r;
  reg  [15:0]             pulse_div_r;
  reg  [31:0]             soft_plus_r;
  reg  [31:0]             soft_minus_r;
  reg  [31:0]             pos_r;
  reg  [31:0]             remain_r;
  reg  [19:0]             tick_r;
  reg  [2:0]              dstep_r;
  reg  [`ERR_WIDTH-1:0]   err_r;
  reg  [`ERR_WIDTH-1:0]   err_nxt;
  reg  [`INT_WIDTH-1:0]   int_stat_r;
  reg  [`INT_WIDTH-1:0]   int_stat_nxt;
  reg  [`INT_WIDTH-1:0]   int_mask_r;
  reg  [3:0]              sync1_r;
  reg  [3:0]              sync2_r;
  reg                     start_dir;
  reg  [31:0]             start_cnt;
  reg  [31:0]             read_mux;
  reg  [`ERR_WIDTH-1:0]   src_vec;
  reg                     dir_eff;

  wire                    any_rst;
  wire                    cmd_wr;
  wire [7:0]              cmd_code;
  wire                    start_cmd;
  wire                    err_clear_cmd;
  wire                    busy;
  wire                    active;
  wire [19:0]             half_period;
  wire                    tick_done;
  wire                    pulse_fall;
  wire                    hard_hit;
  wire                    soft_hit;
  wire                    finish_ev;
  wire                    error_ev;
  wire                    instant_stop_cmd;
  wire                    decel_stop_cmd;
  wire [31:0]             abs_dist;

  assign cmd_wr        = wr_en_in && (addr_in == `REG_CMD);
  assign cmd_code      = wr_data_in[7:0];
  // a command reset behaves exactly like the reset pin
  assign any_rst       = !rst_n_in || (cmd_wr && cmd_code == `CMD_SOFT_RESET);
  assign busy          = (state_r != ST_IDLE);
  // drive commands while busy are dropped, the running drive owns the counter
  assign start_cmd     = cmd_wr && !busy && (cmd_code == `CMD_REL_DRIVE ||
                         cmd_code == `CMD_CREL_DRIVE || cmd_code == `CMD_ABS_DRIVE);
  assign err_clear_cmd = cmd_wr && (cmd_code == `CMD_ERR_CLEAR);
  assign instant_stop_cmd = cmd_wr && (cmd_code == `CMD_INSTANT_STOP);
  assign decel_stop_cmd   = cmd_wr && (cmd_code == `CMD_DECEL_STOP);
  // signed distance to the destination, its sign picks the direction
  assign abs_dist      = pos_param_r - pos_r;
  // [RULE6] errors counted only while driving
  assign active        = start_cmd || busy;

  // pin inputs through two flops before use
  // reset to the inactive level, so no error shows right after reset
  always @(posedge mclk_in) begin
    if (any_rst) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end else begin
      sync1_r <= {emg_stop_n_in, ~servo_alarm_in, minus_limit_input_n_in, plus_limit_input_n_in};
      sync2_r <= sync1_r;
    end
  end

  // start direction and pulse count for each drive type
  always @* begin
    start_dir = `DIR_PLUS;
    start_cnt = 32'h0;
    case (cmd_code)
      // [RULE1] sign picks the direction
      `CMD_REL_DRIVE: begin
        start_dir = pos_param_r[31] ? `DIR_MINUS : `DIR_PLUS;
        start_cnt = magnitude(pos_param_r);
      end
      // [RULE2] always minus
      `CMD_CREL_DRIVE: begin
        start_dir = `DIR_MINUS;
        start_cnt = magnitude(pos_param_r);
      end
      // [RULE3] distance to the destination
      `CMD_ABS_DRIVE: begin
        start_dir = abs_dist[31] ? `DIR_MINUS : `DIR_PLUS;
        start_cnt = magnitude(abs_dist);
      end
      default: begin
        start_dir = `DIR_PLUS;
        start_cnt = 32'h0;
      end
    endcase
  end

  // error sources, the limits qualified by direction and enables
  always @* begin
    dir_eff = start_cmd ? start_dir : dir_out;
    src_vec = {`ERR_WIDTH{1'b0}};
    // [RULE12] compare against the limit of the travel direction
    src_vec[`ERR_SOFT_PLUS]  = config_r[`CFG_SOFT_EN] && dir_eff == `DIR_PLUS &&
                               ($signed(pos_r) >= $signed(soft_plus_r));
    src_vec[`ERR_SOFT_MINUS] = config_r[`CFG_SOFT_EN] && dir_eff == `DIR_MINUS &&
                               ($signed(pos_r) <= $signed(soft_minus_r));
    // [RULE9] disabled limit inputs are ignored
    src_vec[`ERR_HW_PLUS]    = config_r[`CFG_HW_PLUS_EN] && !sync2_r[0] && dir_eff == `DIR_PLUS;
    src_vec[`ERR_HW_MINUS]   = config_r[`CFG_HW_MINUS_EN] && !sync2_r[1] && dir_eff == `DIR_MINUS;
    src_vec[`ERR_ALARM]      = !sync2_r[2];
    src_vec[`ERR_EMG]        = !sync2_r[3];
  end

  // [RULE7] clear command or new drive empties the register
  // [RULE4] set wins over the clear in the same cycle
  always @* begin
    err_nxt = (err_clear_cmd || start_cmd) ? {`ERR_WIDTH{1'b0}} : err_r;
    if (active) begin
      err_nxt = err_nxt | src_vec;
    end
  end

  assign hard_hit   = active && (|src_vec[`ERR_EMG:`ERR_HW_PLUS]);
  assign soft_hit   = active && (|src_vec[`ERR_SOFT_MINUS:`ERR_SOFT_PLUS]);
  // decelerating stop stretches the half period by doubling per pulse
  assign half_period = {4'h0, pulse_div_r} << dstep_r;
  assign tick_done  = (tick_r + 20'h1 >= half_period);
  assign pulse_fall = busy && tick_done && pulse_out;

  // drive sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // a drive that starts on an error or with nothing to do ends at once
        if (start_cmd && !hard_hit && !soft_hit && start_cnt != 32'h0) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (hard_hit || instant_stop_cmd) begin
          state_nxt = ST_IDLE;
        // [RULE11] selected stop type
        end else if (soft_hit) begin
          state_nxt = config_r[`CFG_SOFT_INSTANT] ? ST_IDLE : ST_DECEL;
        end else if (decel_stop_cmd) begin
          state_nxt = ST_DECEL;
        // [RULE3] stop when the remaining count runs out
        end else if (pulse_fall && remain_r == 32'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_DECEL: begin
        // soft limit in decel: keep slowing, last pulses may pass the limit
        if (hard_hit || instant_stop_cmd) begin
          state_nxt = ST_IDLE;
        end else if (pulse_fall && (remain_r == 32'h1 || dstep_r == `DECEL_PULSES - 3'h1)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_in) begin
    if (any_rst) begin
      state_r   <= ST_IDLE;
      tick_r    <= 20'h0;
      dstep_r   <= 3'h0;
      remain_r  <= 32'h0;
      pulse_out <= 1'b0;
      dir_out   <= `DIR_PLUS;
    end else begin
      state_r <= state_nxt;
      if (start_cmd) begin
        dir_out  <= start_dir;
        remain_r <= start_cnt;
        tick_r   <= 20'h0;
        dstep_r  <= 3'h0;
      end else if (state_nxt == ST_IDLE) begin
        pulse_out <= 1'b0;
        tick_r    <= 20'h0;
        dstep_r   <= 3'h0;
      end else if (tick_done) begin
        tick_r    <= 20'h0;
        pulse_out <= ~pulse_out;
        if (pulse_out) begin
          remain_r <= remain_r - 32'h1;
          if (state_r == ST_DECEL) begin
            dstep_r <= dstep_r + 3'h1;
          end
        end
      end else begin
        tick_r <= tick_r + 20'h1;
      end
    end
  end

  // [RULE5] error bits hold until cleared
  always @(posedge mclk_in) begin
    if (any_rst) begin
      err_r <= {`ERR_WIDTH{1'b0}};
    end else begin
      err_r <= err_nxt;
    end
  end

  assign finish_ev = (busy && state_nxt == ST_IDLE) || (start_cmd && state_nxt == ST_IDLE);
  assign error_ev  = |(err_nxt & ~err_r);

  // interrupt status: write one to clear, new events win
  always @* begin
    int_stat_nxt = int_stat_r;
    if (wr_en_in && addr_in == `REG_INT_STAT) begin
      int_stat_nxt = int_stat_nxt & ~wr_data_in[`INT_WIDTH-1:0];
    end
    int_stat_nxt[`INT_FINISH] = int_stat_nxt[`INT_FINISH] | finish_ev;
    int_stat_nxt[`INT_ERROR]  = int_stat_nxt[`INT_ERROR] | error_ev;
  end

  always @(posedge mclk_in) begin
    if (any_rst) begin
      int_stat_r <= {`INT_WIDTH{1'b0}};
      irq_out    <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      // a new mask takes effect one edge after its write
      irq_out    <= |(int_stat_nxt & int_mask_r);
    end
  end

  // software registers and logical position counter
  always @(posedge mclk_in) begin
    if (any_rst) begin
      pos_param_r  <= 32'h0;
      config_r     <= `CFG_RESET;
      pulse_div_r  <= `PULSE_DIV_RESET;
      soft_plus_r  <= `SOFT_PLUS_RESET;
      soft_minus_r <= `SOFT_MINUS_RESET;
      pos_r        <= 32'h0;
      int_mask_r   <= {`INT_WIDTH{1'b0}};
    end else begin
      if (wr_en_in) begin
        case (addr_in)
          `REG_POS_PARAM: pos_param_r <= wr_data_in;
          `REG_CONFIG:    config_r    <= wr_data_in[`CFG_WIDTH-1:0];
          // zero would keep a decelerating stop from doubling the half period, so it is raised to one
          `REG_PULSE_DIV: pulse_div_r <= (wr_data_in[15:0] == 16'h0) ? 16'h1 : wr_data_in[15:0];
          // [RULE10] dedicated limit registers
          `REG_SOFT_PLUS:  soft_plus_r  <= wr_data_in;
          `REG_SOFT_MINUS: soft_minus_r <= wr_data_in;
          `REG_INT_MASK:   int_mask_r   <= wr_data_in[`INT_WIDTH-1:0];
          default: begin
          end
        endcase
      end
      // position is writable only while idle
      // counted at the falling edge, so a pulse cut short by a stop is not counted
      if (pulse_fall) begin
        pos_r <= (dir_out == `DIR_PLUS) ? pos_r + 32'h1 : pos_r - 32'h1;
      end else if (!busy && wr_en_in && addr_in == `REG_LOGICAL_POS) begin
        pos_r <= wr_data_in;
      end
    end
  end

  // read mux, unmapped and write-only addresses read zero
  always @* begin
    case (addr_in)
      `REG_POS_PARAM:   read_mux = pos_param_r;
      `REG_CONFIG:      read_mux = {28'h0, config_r};
      `REG_PULSE_DIV:   read_mux = {16'h0, pulse_div_r};
      `REG_SOFT_PLUS:   read_mux = soft_plus_r;
      `REG_SOFT_MINUS:  read_mux = soft_minus_r;
      `REG_LOGICAL_POS: read_mux = pos_r;
      `REG_DRIVE_STAT:  read_mux = {26'h0, ~sync2_r[3], ~sync2_r[2], state_r == ST_DECEL, dir_out, busy, 1'b0};
      `REG_ERROR_STAT:  read_mux = {26'h0, err_r};
      `REG_INT_STAT:    read_mux = {30'h0, int_stat_r};
      `REG_INT_MASK:    read_mux = {30'h0, int_mask_r};
      default:          read_mux = 32'h0;
    endcase
  end

  always @(posedge mclk_in) begin
    if (any_rst) begin
      rd_data_out <= 32'h0;
    end else begin
      rd_data_out <= rd_en_in ? read_mux : 32'h0;
    end
  end

endmodule // axis_drive_error_limit_logic

// File: bench/axis_drive_properties.sv
// port-level checks for the axis drive
`timescale 1ns/1ps
`include "axis_drive_defines.vh"
module axis_drive_properties (
  // clock and reset
  input wire        mclk_in,
  input wire        rst_n_in,
  // register port
  input wire [7:0]  addr_in,
  input wire [31:0] wr_data_in,
  input wire        wr_en_in,
  input wire        rd_en_in,
  input wire [31:0] rd_data_out,
  // driver side and host interrupt
  input wire        plus_limit_input_n_in,
  input wire        minus_limit_input_n_in,
  input wire        servo_alarm_in,
  input wire        emg_stop_n_in,
  input wire        pulse_out,
  input wire        dir_out,
  input wire        irq_out
);
  reg  [31:0] par_r;
  reg  [3:0]  cfg_r;
  reg  [1:0]  msk_r;
  wire        cmd_w = wr_en_in && addr_in == `REG_CMD;
  wire [7:0]  op_w  = wr_data_in[7:0];
  // shadows follow the same write edge as the device
  always @(posedge mclk_in) begin
    if (!rst_n_in || (cmd_w && op_w == `CMD_SOFT_RESET)) begin
      par_r <= 32'h0;
      cfg_r <= `CFG_RESET;
      msk_r <= 2'h0;
    end else if (wr_en_in) begin
      if (addr_in == `REG_POS_PARAM)
        par_r <= wr_data_in;
      if (addr_in == `REG_CONFIG)
        cfg_r <= wr_data_in[3:0];
      if (addr_in == `REG_INT_MASK)
        msk_r <= wr_data_in[1:0];
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 32'h0)
    else $error("read data outside read cycle");
  a_rd_cmd_zero: assert property (rd_en_in && addr_in == `REG_CMD |=> rd_data_out == 32'h0)
    else $error("command register read not zero");
  a_rel_dir_sign: assert property (
    cmd_w && op_w == `CMD_REL_DRIVE |=> dir_out == !par_r[31]) else $error("relative direction wrong");
  a_crel_dir_minus: assert property (
    cmd_w && op_w == `CMD_CREL_DRIVE |=> dir_out == `DIR_MINUS) else $error("counter relative not minus");
  a_emg_no_pulse: assert property (
    (!emg_stop_n_in)[*5] |-> !pulse_out) else $error("pulse during emergency stop");
  a_alarm_no_pulse: assert property (
    servo_alarm_in[*5] |-> !pulse_out) else $error("pulse during servo alarm");
  a_hw_plus_stop: assert property (
    (!plus_limit_input_n_in && cfg_r[`CFG_HW_PLUS_EN] && dir_out)[*5] |-> !pulse_out)
    else $error("pulse into enabled plus limit");
  a_hw_minus_stop: assert property (
    (!minus_limit_input_n_in && cfg_r[`CFG_HW_MINUS_EN] && !dir_out)[*5] |-> !pulse_out)
    else $error("pulse into enabled minus limit");
  a_mask_irq_low: assert property ((msk_r == 2'h0)[*2] |-> !irq_out)
    else $error("interrupt while fully masked");
  a_soft_reset_idle: assert property (
    cmd_w && op_w == `CMD_SOFT_RESET |=> !pulse_out && dir_out && !irq_out) else $error("command reset state");
endmodule // axis_drive_properties

// File: bench/motor_driver_model.sv
// motor driver with limit switches, alarm and stop button
`timescale 1ns/1ps
module motor_driver_model (
  // clock
  input  wire        mclk_in,
  // pins from the axis
  input  wire        pulse_in,
  input  wire        dir_in,
  // bench controls
  input  wire        lim_p_in,
  input  wire        lim_m_in,
  input  wire        alarm_in,
  input  wire        emg_in,
  // pins to the axis, and the step count for the bench
  output wire        plus_limit_n_out,
  output wire        minus_limit_n_out,
  output wire        servo_alarm_out,
  output wire        emg_stop_n_out,
  output reg  [31:0] steps_out
);
  reg pulse_d = 1'b0;
  initial steps_out = 32'h0;
  // switches pull up, so inactive reads high
  assign plus_limit_n_out  = !lim_p_in;
  assign minus_limit_n_out = !lim_m_in;
  assign servo_alarm_out   = alarm_in;
  assign emg_stop_n_out    = !emg_in;
  // motor steps on the rising pulse edge
  always @(posedge mclk_in) begin
    pulse_d <= pulse_in;
    if (pulse_in && !pulse_d)
      steps_out <= dir_in ? steps_out + 32'h1 : steps_out - 32'h1;
  end
endmodule // motor_driver_model

// File: bench/axis_drive_error_limit_logic_tb_top.sv
// self-checking bench for the axis drive logic
`timescale 1ns/1ps
`include "axis_drive_defines.vh"
module axis_drive_error_limit_logic_tb_top;
  reg         mclk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg  [7:0]  addr = 8'h0;
  reg  [31:0] wdata = 32'h0;
  reg         wr_en = 1'b0;
  reg         rd_en = 1'b0;
  reg         lim_p = 1'b0;
  reg         lim_m = 1'b0;
  reg         alarm = 1'b0;
  reg         emg = 1'b0;
  wire [31:0] rdata;
  wire [31:0] steps;
  wire        pls, dir, irq, lp_n, lm_n, alm, es_n;
  integer     n_errors = 0;
  integer     tests_run = 0;
  integer     i;
  reg  [31:0] v;
  always #2.5 mclk_in = !mclk_in;
  axis_drive_error_limit_logic i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
    .plus_limit_input_n_in(lp_n), .minus_limit_input_n_in(lm_n), .servo_alarm_in(alm),
    .emg_stop_n_in(es_n), .pulse_out(pls), .dir_out(dir), .irq_out(irq));
  motor_driver_model i_motor (.mclk_in(mclk_in), .pulse_in(pls), .dir_in(dir), .lim_p_in(lim_p),
    .lim_m_in(lim_m), .alarm_in(alarm), .emg_in(emg), .plus_limit_n_out(lp_n),
    .minus_limit_n_out(lm_n), .servo_alarm_out(alm), .emg_stop_n_out(es_n), .steps_out(steps));
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk_in);
    wr_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe; taken at that cycle's closing edge
  task rdq(input [7:0] a);
    @(posedge mclk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk_in);
    rd_en <= 1'b0;
    @(posedge mclk_in);
    v = rdata;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    rdq(a);
    chk(v, e);
  endtask
  // bounded poll of the busy flag; a drive that never ends aborts the sequence
  task wait_idle;
    for (i = 0; i < 400; i = i + 1) begin
      rdq(`REG_DRIVE_STAT);
      if (v[1] === 1'b0)
        i = 1000;
    end
    if (i < 1000) begin
      n_errors = n_errors + 1;
      disable seq;
    end
  endtask
  task go(input [7:0] c, input [31:0] p);
    wr(`REG_POS_PARAM, p);
    wr(`REG_CMD, {24'h0, c});
    wait_idle;
  endtask
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    begin : seq
      rd(`REG_CONFIG, 32'h3);
      rd(`REG_SOFT_PLUS, 32'h7FFFFFFF);
      rd(`REG_SOFT_MINUS, 32'h80000000);
      rd(8'h3C, 32'h0);
      wr(`REG_PULSE_DIV, 32'h2);
      go(`CMD_REL_DRIVE, 32'h5);
      chk(steps, 32'h5);
      go(`CMD_REL_DRIVE, 32'hFFFFFFFD);
      chk(steps, 32'h2);
      go(`CMD_CREL_DRIVE, 32'h4);
      chk(steps, 32'hFFFFFFFE);
      go(`CMD_ABS_DRIVE, 32'h7);
      chk(steps, 32'h7);
      rd(`REG_LOGICAL_POS, 32'h7);
      // soft limit at 10, instant then decelerating stop
      wr(`REG_SOFT_PLUS, 32'hA);
      wr(`REG_CONFIG, 32'hF);
      go(`CMD_REL_DRIVE, 32'h14);
      rd(`REG_LOGICAL_POS, 32'hA);
      rd(`REG_ERROR_STAT, 32'h1);
      wr(`REG_LOGICAL_POS, 32'h7);
      wr(`REG_CONFIG, 32'h7);
      go(`CMD_REL_DRIVE, 32'h14);
      rd(`REG_LOGICAL_POS, 32'hE);
      // beyond the plus limit a minus move is still free
      go(`CMD_REL_DRIVE, 32'hFFFFFFFE);
      rd(`REG_LOGICAL_POS, 32'hC);
      rd(`REG_ERROR_STAT, 32'h0);
      emg <= 1'b1;
      alarm <= 1'b1;
      repeat (6) @(posedge mclk_in);
      rd(`REG_ERROR_STAT, 32'h0);
      go(`CMD_ABS_DRIVE, 32'h7);
      rd(`REG_ERROR_STAT, 32'h30);
      rd(`REG_LOGICAL_POS, 32'hC);
      emg <= 1'b0;
      alarm <= 1'b0;
      repeat (4) @(posedge mclk_in);
      rd(`REG_ERROR_STAT, 32'h30);
      // the clear goes out only after the poll has seen the drive stopped
      wr(`REG_CMD, {24'h0, `CMD_ERR_CLEAR});
      rd(`REG_ERROR_STAT, 32'h0);
      // level interrupt: unmask, mask, clear
      wr(`REG_INT_MASK, 32'h3);
      repeat (3) @(posedge mclk_in);
      chk({31'h0, irq}, 32'h1);
      wr(`REG_INT_MASK, 32'h0);
      repeat (3) @(posedge mclk_in);
      chk({31'h0, irq}, 32'h0);
      wr(`REG_INT_MASK, 32'h3);
      wr(`REG_INT_STAT, 32'h3);
      repeat (3) @(posedge mclk_in);
      chk({31'h0, irq}, 32'h0);
      rd(`REG_INT_STAT, 32'h0);
      // plus limit ignored when disabled, refuses when enabled
      lim_p <= 1'b1;
      wr(`REG_CONFIG, 32'h2);
      go(`CMD_REL_DRIVE, 32'h3);
      rd(`REG_LOGICAL_POS, 32'hF);
      rd(`REG_ERROR_STAT, 32'h0);
      wr(`REG_CONFIG, 32'h3);
      go(`CMD_REL_DRIVE, 32'h3);
      rd(`REG_LOGICAL_POS, 32'hF);
      rd(`REG_ERROR_STAT, 32'h4);
      // minus limit refuses a minus move, a plus move stays free
      lim_p <= 1'b0;
      lim_m <= 1'b1;
      go(`CMD_REL_DRIVE, 32'hFFFFFFFD);
      rd(`REG_LOGICAL_POS, 32'hF);
      rd(`REG_ERROR_STAT, 32'h8);
      go(`CMD_REL_DRIVE, 32'h1);
      rd(`REG_LOGICAL_POS, 32'h10);
      rd(`REG_ERROR_STAT, 32'h0);
      lim_m <= 1'b0;
      // instant stop cuts before the first pulse, decelerating stop adds four
      wr(`REG_POS_PARAM, 32'h14);
      wr(`REG_CMD, {24'h0, `CMD_REL_DRIVE});
      wr(`REG_CMD, {24'h0, `CMD_INSTANT_STOP});
      rd(`REG_DRIVE_STAT, 32'h4);
      rd(`REG_LOGICAL_POS, 32'h10);
      wr(`REG_CMD, {24'h0, `CMD_REL_DRIVE});
      wr(`REG_CMD, {24'h0, `CMD_DECEL_STOP});
      wait_idle;
      rd(`REG_LOGICAL_POS, 32'h14);
      // soft minus limit with instant stop
      wr(`REG_SOFT_MINUS, 32'hE);
      wr(`REG_CONFIG, 32'hC);
      go(`CMD_REL_DRIVE, 32'hFFFFFFF9);
      rd(`REG_LOGICAL_POS, 32'hE);
      rd(`REG_ERROR_STAT, 32'h2);
      wr(`REG_CMD, {24'h0, `CMD_SOFT_RESET});
      rd(`REG_CONFIG, 32'h3);
      rd(`REG_PULSE_DIV, 32'h64);
    end
    test_done;
  end
endmodule // axis_drive_error_limit_logic_tb_top
bind axis_drive_error_limit_logic axis_drive_properties i_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .plus_limit_input_n_in(plus_limit_input_n_in),
  .minus_limit_input_n_in(minus_limit_input_n_in), .servo_alarm_in(servo_alarm_in),
  .emg_stop_n_in(emg_stop_n_in), .pulse_out(pulse_out), .dir_out(dir_out), .irq_out(irq_out));
